// *** tb/dpll_holdover_frequency_control_asserts.sv ***
// Port-level checks of the holdover control block
`timescale 1ns/1ps
module dpll_holdover_frequency_control_asserts #(
    parameter logic [35:0] PRELOCK2_LIMIT = 36'd50
) (
    input wire logic mclk,
    input wire logic reset,
    input holdover_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdata_valid,
    input holdover_pkg::loop_events_t loop_ev,
    input wire logic force_locked,
    input wire logic aux_lock_achieved,
    input wire logic aux_ref_lost,
    input holdover_pkg::freq_override_t freq_override,
    input wire logic [2:0] main_loop_state,
    input wire logic ref_disqualify,
    input wire logic phase_alarm,
    input wire logic reselect_request,
    input wire logic aux_locked
);
    import holdover_pkg::*;
    logic [35:0] p2_cnt;
    logic manual_q;
    logic [18:0] hold_q;
    wire logic in_p2 = main_loop_state == LOOP_PRELOCK2;
    wire logic in_hold = main_loop_state == LOOP_HOLDOVER;
    wire logic in_lock = main_loop_state == LOOP_LOCKED;
    wire logic wr_on = reg_req.wr;

    // Shadows of host writes, time in pre-lock
    always_ff @(posedge mclk) begin
        if (reset) begin
            p2_cnt <= 36'h0;
            manual_q <= 1'b0;
            hold_q <= HOLD_SET_RST;
        end else begin
            p2_cnt <= in_p2 ? p2_cnt + 36'h1 : 36'h0;
            if (wr_on && reg_req.addr == ADDR_INPUT_CFG)
                manual_q <= reg_req.wdata[MANUAL_HOLD_BIT];
            if (wr_on && reg_req.addr == ADDR_HOLD_SET_A)
                hold_q[7:0] <= reg_req.wdata;
            if (wr_on && reg_req.addr == ADDR_HOLD_SET_B)
                hold_q[15:8] <= reg_req.wdata;
            if (wr_on && reg_req.addr == ADDR_HOLD_CFG)
                hold_q[18:16] <= reg_req.wdata[2:0];
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    AST_RD_VALID: assert property (reg_req.rd |=> reg_rdata_valid)
        else $error("no read valid");
    AST_STATE_RPT: assert property (
        reg_req.rd && !reg_req.wr && reg_req.addr == ADDR_STATE_RPT
        |=> reg_rdata == {5'h00, $past(main_loop_state)})
        else $error("bad state");
    AST_HOLD_ENTRY: assert property (
        in_lock && loop_ev.ref_invalid && !loop_ev.replacement_avail
        && !force_locked |=> in_hold)
        else $error("no hold");
    AST_P2_ENTRY: assert property (
        in_hold && loop_ev.source_applied && !force_locked |=> in_p2)
        else $error("no prelock");
    AST_REVERT: assert property (
        in_hold && loop_ev.revertive && loop_ev.higher_prio_restored
        && !force_locked |=> in_p2)
        else $error("no revert");
    AST_ALARM_SET: assert property (
        ref_disqualify |-> phase_alarm && reselect_request && in_hold
        && $past(main_loop_state) == LOOP_PRELOCK2)
        else $error("bad alarm");
    AST_P2_BOUND: assert property (
        p2_cnt <= PRELOCK2_LIMIT + 36'h3)
        else $error("prelock long");
    AST_MANUAL_WORD: assert property (
        (in_hold && manual_q) ##1 (in_hold && manual_q && $stable(hold_q))
        |-> freq_override.active && freq_override.word == hold_q)
        else $error("bad manual");
    AST_FREEZE_ON: assert property (
        in_lock && $rose(loop_ev.input_stopped) |=> freq_override.active)
        else $error("no freeze");
    AST_FREEZE_OFF: assert property (
        in_lock && !loop_ev.input_stopped && !loop_ev.ref_invalid
        |=> !freq_override.active)
        else $error("freeze stuck");
    AST_AUX: assert property (
        aux_lock_achieved || aux_ref_lost
        |=> aux_locked == $past(aux_lock_achieved))
        else $error("bad aux");

    cover property (ref_disqualify);
    cover property (in_lock && $rose(loop_ev.input_stopped));
    cover property (in_hold ##1 in_p2);
endmodule

// *** tb/dpll_holdover_frequency_control_tb.sv ***
// Self-checking bench for the holdover control block
`timescale 1ns/1ps
module dpll_holdover_frequency_control_tb;
    import holdover_pkg::*;
    logic mclk;
    logic reset;
    reg_req_t reg_req;
    loop_events_t ev_drv;
    loop_events_t loop_ev;
    freq_override_t freq_override;
    logic force_locked, aux_lock_achieved, aux_ref_lost, ref_stop;
    logic [18:0] target_freq, integral_freq, hw, k_a, k_b;
    logic [7:0] reg_rdata, d;
    logic [2:0] main_loop_state;
    logic reg_rdata_valid, ref_disqualify, phase_alarm;
    logic reselect_request, aux_locked, stopped_w;
    int miscompares = 0;
    int total_checks = 0;
    int seed = 57;
    int i;

    assign loop_ev = {ev_drv[7:1], stopped_w};

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    dpll_holdover_frequency_control #(.PRELOCK2_LIMIT(36'd50),
        .FILT_TICK(32'd4)) dpll_holdover_frequency_control_i (
        .mclk(mclk), .reset(reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .integral_freq(integral_freq), .loop_ev(loop_ev),
        .force_locked(force_locked), .aux_lock_achieved(aux_lock_achieved),
        .aux_ref_lost(aux_ref_lost), .freq_override(freq_override),
        .main_loop_state(main_loop_state), .ref_disqualify(ref_disqualify),
        .phase_alarm(phase_alarm), .reselect_request(reselect_request),
        .aux_locked(aux_locked));

    ref_loop_model ref_loop_model_i (.mclk(mclk), .reset(reset),
        .target_freq(target_freq), .ref_stop(ref_stop),
        .integral_freq(integral_freq), .input_stopped(stopped_w));

    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_req <= '{1'b1, 1'b0, a, v};
        @(posedge mclk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        #1;
        chk(19'(reg_rdata_valid), 19'h00001);
        chk(19'(reg_rdata), 19'(e));
    endtask

    task automatic set_cfg(input logic [1:0] src, input logic rb,
            input logic avg);
        wr(ADDR_HOLD_CFG, {avg, 1'b1, rb, src, hw[18:16]});
    endtask

    task automatic wr_hold(input logic [18:0] h);
        hw = h;
        wr(ADDR_HOLD_SET_A, h[7:0]);
        wr(ADDR_HOLD_SET_B, h[15:8]);
        set_cfg(FRZ_LAST_GOOD, 1'b0, 1'b1);
    endtask

    task automatic pulse(input int b);
        @(posedge mclk);
        ev_drv[b] <= 1'b1;
        @(posedge mclk);
        ev_drv[b] <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    function automatic logic [18:0] frz_word(input logic [1:0] src);
        case (src)
            FRZ_HOLD_SET: return hw;
            FRZ_ZERO: return FREQ_ZERO;
            default: return k_a;
        endcase
    endfunction

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        reg_req = '0;
        ev_drv = '0;
        {force_locked, aux_lock_achieved, aux_ref_lost, ref_stop} = 4'h0;
        hw = 19'h00000;
        k_a = 19'($random(seed));
        k_b = 19'($random(seed));
        target_freq = k_a;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        #1;
        chk(19'(main_loop_state), 19'(LOOP_FREE_RUN));
        chk(19'(aux_locked), 19'h00000);
        rd(ADDR_INPUT_CFG, INPUT_CFG_RST);
        rd(ADDR_HOLD_CFG, HOLD_CFG_RST);
        d = 8'($random(seed));
        wr(ADDR_INPUT_CFG, d);
        rd(ADDR_INPUT_CFG, d & 8'h10);
        wr(ADDR_INPUT_CFG, 8'h00);
        wr(8'h55, 8'hA5);
        rd(8'h55, 8'h00);
        wr(ADDR_STATE_RPT, 8'hFF);
        rd(ADDR_STATE_RPT, 8'(LOOP_FREE_RUN));
        wr_hold(19'($random(seed)));
        rd(ADDR_HOLD_SET_B, hw[15:8]);
        rd(ADDR_HOLD_CFG, {5'h18, hw[18:16]});
        pulse(1);
        chk(19'(main_loop_state), 19'(LOOP_LOCKED));
        rd(ADDR_FREQ_STS_A, k_a[7:0]);
        rd(ADDR_FREQ_STS_B, k_a[15:8]);
        rd(ADDR_FREQ_STS_C, {5'h00, k_a[18:16]});
        repeat (60) @(posedge mclk);
        for (i = 0; i < 4; i++) begin
            set_cfg(2'(i), 1'b0, 1'b1);
            ref_stop <= 1'b1;
            repeat (4) @(posedge mclk);
            #1;
            chk(19'(freq_override.active), 19'h00001);
            chk(freq_override.word, frz_word(2'(i)));
            @(posedge mclk);
            ref_stop <= 1'b0;
            repeat (4) @(posedge mclk);
            #1;
            chk(19'(freq_override.active), 19'h00000);
        end
        set_cfg(FRZ_LAST_GOOD, 1'b1, 1'b1);
        rd(ADDR_HOLD_SET_A, k_a[7:0]);
        set_cfg(FRZ_LAST_GOOD, 1'b0, 1'b1);
        target_freq <= k_b;
        pulse(5);
        chk(19'(main_loop_state), 19'(LOOP_HOLDOVER));
        chk(freq_override.word, k_a);
        wr(ADDR_INPUT_CFG, 8'h10);
        wr_hold(19'($random(seed)));
        repeat (3) @(posedge mclk);
        #1;
        chk(freq_override.word, hw);
        pulse(7);
        chk(19'(main_loop_state), 19'(LOOP_PRELOCK2));
        for (i = 0; i < 200 && ref_disqualify !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        chk(19'({ref_disqualify, phase_alarm, reselect_request}),
            19'h00007);
        chk(19'(main_loop_state), 19'(LOOP_HOLDOVER));
        @(posedge mclk);
        ev_drv.revertive <= 1'b1;
        pulse(2);
        chk(19'(main_loop_state), 19'(LOOP_PRELOCK2));
        ev_drv.revertive <= 1'b0;
        force_locked <= 1'b1;
        @(posedge mclk);
        force_locked <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk(19'(main_loop_state), 19'(LOOP_LOCKED));
        wr(ADDR_INPUT_CFG, 8'h00);
        set_cfg(FRZ_LAST_GOOD, 1'b0, 1'b0);
        pulse(5);
        chk(freq_override.word, k_b);
        @(posedge mclk);
        target_freq <= k_a;
        repeat (6) @(posedge mclk);
        #1;
        chk(freq_override.word, k_b);
        @(posedge mclk);
        aux_lock_achieved <= 1'b1;
        @(posedge mclk);
        aux_lock_achieved <= 1'b0;
        aux_ref_lost <= 1'b1;
        #1;
        chk(19'(aux_locked), 19'h00001);
        @(posedge mclk);
        aux_ref_lost <= 1'b0;
        #1;
        chk(19'(aux_locked), 19'h00000);
        give_verdict;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        give_verdict;
    end
endmodule

bind dpll_holdover_frequency_control dpll_holdover_frequency_control_asserts
    #(.PRELOCK2_LIMIT(PRELOCK2_LIMIT)) chk_i (
    .mclk(mclk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .loop_ev(loop_ev),
    .force_locked(force_locked), .aux_lock_achieved(aux_lock_achieved),
    .aux_ref_lost(aux_ref_lost), .freq_override(freq_override),
    .main_loop_state(main_loop_state), .ref_disqualify(ref_disqualify),
    .phase_alarm(phase_alarm), .reselect_request(reselect_request),
    .aux_locked(aux_locked));

// *** tb/ref_loop_model.sv ***
// Loop side model: integral word that settles late, input activity
`timescale 1ns/1ps
module ref_loop_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [18:0] target_freq,
    input wire logic ref_stop,
    output logic [18:0] integral_freq,
    output logic input_stopped
);
    logic [18:0] settle_reg;

    // Two-stage lag stands in for the loop integrator catching up
    always_ff @(posedge mclk) begin
        if (reset) begin
            settle_reg <= 19'h00000;
            integral_freq <= 19'h00000;
            input_stopped <= 1'b0;
        end else begin
            settle_reg <= target_freq;
            integral_freq <= settle_reg;
            input_stopped <= ref_stop;
        end
    end
endmodule

// *** verilog/dpll_holdover_frequency_control.sv ***
// Holdover frequency control and state handling for the primary loop
`timescale 1ns/1ps

// Overview of operation
// - Averaging bit picks averaged or instantaneous holdover
// - Averaged holdover uses IIR-filtered live frequency
// - Short filter time constant about 76 s, else about 20 min
// - Instantaneous holdover freezes integral value only
// - Manual holdover uses 19-bit signed written word
// - Live loop frequency reported from integral path
// - Readback bit returns averaged value on reads
// - Stopped input enters brief freeze, source selectable
// - Brief freeze ends on reselect, holdover, recovery
// - Primary state reported in low three bits
// - Auxiliary loop: zero-offset holdover or locked
// - Holdover to second pre-locked on source applied
// - Revertive higher priority return also enters it
// - 100 s timeout disqualifies, alarms, back to holdover
// - Invalid input without replacement enters holdover
// - Manual select bit: low automatic, high manual
module dpll_holdover_frequency_control #(
    parameter logic [35:0] PRELOCK2_LIMIT =
        36'(holdover_pkg::PRELOCK2_CYCLES),
    parameter logic [31:0] FILT_TICK =
        32'(holdover_pkg::FILT_TICK_CYCLES)
) (
    input wire logic mclk,
    input wire logic reset,
    input holdover_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire logic [18:0] integral_freq,
    input holdover_pkg::loop_events_t loop_ev,
    input wire logic force_locked,
    input wire logic aux_lock_achieved,
    input wire logic aux_ref_lost,
    output holdover_pkg::freq_override_t freq_override,
    output logic [2:0] main_loop_state,
    output logic ref_disqualify,
    output logic phase_alarm,
    output logic reselect_request,
    output logic aux_locked
);
    import holdover_pkg::*;

    // Configuration and status storage
    logic [7:0] input_cfg_reg;
    logic [7:0] hold_cfg_reg;
    logic [18:0] hold_set_reg;
    logic [18:0] live_freq_reg;
    logic [18:0] last_good_reg;
    logic [18:0] inst_word_reg;
    loop_state_t state_reg;
    loop_state_t state_next;
    logic freeze_reg;
    logic freeze_next;
    logic stopped_d_reg;
    logic [18:0] filt_freq;
    logic timeout;

    // Decoded configuration fields
    logic manual_hold_select;
    logic averaging_select;
    logic short_filter_select;
    logic filtered_readback_enable;
    logic [1:0] brief_freeze_source;

    assign manual_hold_select = input_cfg_reg[MANUAL_HOLD_BIT];
    assign averaging_select = hold_cfg_reg[AVERAGING_BIT];
    assign short_filter_select = hold_cfg_reg[SHORT_FILTER_BIT];
    assign filtered_readback_enable = hold_cfg_reg[READBACK_BIT];
    assign brief_freeze_source = hold_cfg_reg[FREEZE_SRC_LSB+1:FREEZE_SRC_LSB];

    // Register write decode
    logic wr_input_cfg;
    logic wr_hold_a;
    logic wr_hold_b;
    logic wr_hold_cfg;

    assign wr_input_cfg = reg_req.wr && (reg_req.addr == ADDR_INPUT_CFG);
    assign wr_hold_a = reg_req.wr && (reg_req.addr == ADDR_HOLD_SET_A);
    assign wr_hold_b = reg_req.wr && (reg_req.addr == ADDR_HOLD_SET_B);
    assign wr_hold_cfg = reg_req.wr && (reg_req.addr == ADDR_HOLD_CFG);

    function automatic logic [7:0] only_bit(input logic [7:0] v,
                                            input int pos);
        logic [7:0] m;
        m = 8'h01 << pos;
        return v & m;
    endfunction

    always_ff @(posedge mclk) begin
        if (reset) begin
            input_cfg_reg <= INPUT_CFG_RST;
        end else if (wr_input_cfg) begin
            input_cfg_reg <= only_bit(reg_req.wdata, MANUAL_HOLD_BIT);
        end
    end

    // Hold word stays writable in every state, holdover included
    always_ff @(posedge mclk) begin
        if (reset) begin
            hold_set_reg <= HOLD_SET_RST;
            hold_cfg_reg <= HOLD_CFG_RST;
        end else begin
            if (wr_hold_a) begin
                hold_set_reg[7:0] <= reg_req.wdata;
            end
            if (wr_hold_b) begin
                hold_set_reg[15:8] <= reg_req.wdata;
            end
            if (wr_hold_cfg) begin
                hold_set_reg[18:16] <= reg_req.wdata[2:0];
                hold_cfg_reg <= {reg_req.wdata[7:3], 3'h0};
            end
        end
    end

    // Read mux: hold word reads back the average when enabled
    logic [18:0] hold_read_word;
    logic [7:0] rd_mux;

    assign hold_read_word = filtered_readback_enable ? filt_freq
                                                     : hold_set_reg;

    always_comb begin
        case (reg_req.addr)
            ADDR_FREQ_STS_C: rd_mux = {5'h00, live_freq_reg[18:16]};
            ADDR_STATE_RPT: rd_mux = {5'h00, state_reg};
            ADDR_FREQ_STS_A: rd_mux = live_freq_reg[7:0];
            ADDR_FREQ_STS_B: rd_mux = live_freq_reg[15:8];
            ADDR_INPUT_CFG: rd_mux = input_cfg_reg;
            ADDR_HOLD_SET_A: rd_mux = hold_read_word[7:0];
            ADDR_HOLD_SET_B: rd_mux = hold_read_word[15:8];
            ADDR_HOLD_CFG: rd_mux = {hold_cfg_reg[7:3], hold_read_word[18:16]};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata <= reg_req.rd ? rd_mux : 8'h00;
            reg_rdata_valid <= reg_req.rd;
        end
    end

    // Live frequency snapshot every cycle; last value taken only while the input runs and no brief freeze is active
    always_ff @(posedge mclk) begin
        if (reset) begin
            live_freq_reg <= FREQ_ZERO;
            last_good_reg <= FREQ_ZERO;
        end else begin
            live_freq_reg <= integral_freq;
            if (!freeze_reg && !loop_ev.input_stopped) begin
                last_good_reg <= integral_freq;
            end
        end
    end

    // Averaging runs only while locked and no brief freeze is active
    logic filt_enable;

    assign filt_enable = (state_reg == LOOP_LOCKED) && !freeze_reg;

    holdover_iir #(
        .TICK_CYCLES(FILT_TICK)
    ) u_iir (
        .mclk(mclk),
        .reset(reset),
        .enable(filt_enable),
        .short_sel(short_filter_select),
        .sample_in(live_freq_reg),
        .filt_out(filt_freq)
    );

    // Primary loop state machine
    logic prelock2_run;
    logic enter_holdover;
    logic locked_req;
    logic restart_req;

    assign prelock2_run = (state_reg == LOOP_PRELOCK2);
    assign locked_req = loop_ev.lock_achieved || force_locked;
    assign restart_req = loop_ev.source_applied
        || (loop_ev.revertive && loop_ev.higher_prio_restored);

    prelock2_timer #(
        .LIMIT(PRELOCK2_LIMIT)
    ) u_timer (
        .mclk(mclk),
        .reset(reset),
        .run(prelock2_run),
        .expired(timeout)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LOOP_FREE_RUN: begin
                if (locked_req) begin
                    state_next = LOOP_LOCKED;
                end
            end
            LOOP_LOCKED: begin
                if (loop_ev.ref_invalid && !loop_ev.replacement_avail) begin
                    state_next = LOOP_HOLDOVER;
                end
            end
            LOOP_HOLDOVER: begin
                if (force_locked) begin
                    state_next = LOOP_LOCKED;
                end else if (restart_req) begin
                    state_next = LOOP_PRELOCK2;
                end
            end
            LOOP_PRELOCK2: begin
                if (locked_req) begin
                    state_next = LOOP_LOCKED;
                end else if (timeout) begin
                    state_next = LOOP_HOLDOVER;
                end
            end
            default: state_next = LOOP_FREE_RUN;
        endcase
    end

    assign enter_holdover = (state_next == LOOP_HOLDOVER)
                         && (state_reg != LOOP_HOLDOVER);

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= LOOP_FREE_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Timeout reports: disqualify the source, alarm it, ask for another
    logic timeout_taken;

    assign timeout_taken = prelock2_run && timeout && !locked_req;

    always_ff @(posedge mclk) begin
        if (reset) begin
            ref_disqualify <= 1'b0;
            phase_alarm <= 1'b0;
            reselect_request <= 1'b0;
        end else begin
            ref_disqualify <= timeout_taken;
            phase_alarm <= timeout_taken;
            reselect_request <= timeout_taken;
        end
    end

    // Instantaneous holdover word: integral value frozen at entry
    always_ff @(posedge mclk) begin
        if (reset) begin
            inst_word_reg <= FREQ_ZERO;
        end else if (enter_holdover) begin
            inst_word_reg <= last_good_reg;
        end
    end

    // Brief freeze on a stopped input
    logic stop_rise;

    assign stop_rise = loop_ev.input_stopped && !stopped_d_reg;

    always_comb begin
        freeze_next = freeze_reg;
        if (freeze_reg) begin
            if (loop_ev.source_changed || enter_holdover
                || (state_reg == LOOP_HOLDOVER)
                || !loop_ev.input_stopped) begin
                freeze_next = 1'b0;
            end
        end else if (stop_rise && (state_reg != LOOP_HOLDOVER)
                     && !enter_holdover) begin
            freeze_next = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            freeze_reg <= 1'b0;
            stopped_d_reg <= 1'b0;
        end else begin
            freeze_reg <= freeze_next;
            stopped_d_reg <= loop_ev.input_stopped;
        end
    end

    // Holdover word selection
    logic [18:0] auto_word;
    logic [18:0] hold_word;
    logic [18:0] freeze_word;
    logic hold_active;

    assign auto_word = averaging_select ? filt_freq : inst_word_reg;
    assign hold_word = manual_hold_select ? hold_set_reg
                                          : auto_word;
    assign hold_active = (state_reg == LOOP_HOLDOVER);

    always_comb begin
        case (brief_freeze_source)
            FRZ_LAST_GOOD: freeze_word = last_good_reg;
            FRZ_AVERAGED: freeze_word = filt_freq;
            FRZ_HOLD_SET: freeze_word = hold_set_reg;
            FRZ_ZERO: freeze_word = FREQ_ZERO;
            default: freeze_word = last_good_reg;
        endcase
    end

    // Override replaces both loop paths while holding or freezing
    always_ff @(posedge mclk) begin
        if (reset) begin
            freq_override <= '0;
        end else begin
            freq_override.active <= hold_active || freeze_next;
            freq_override.word <= hold_active ? hold_word
                                              : freeze_word;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            main_loop_state <= LOOP_FREE_RUN;
        end else begin
            main_loop_state <= state_next;
        end
    end

    // Auxiliary loop: starts in zero-offset holdover, locked is its only other state
    always_ff @(posedge mclk) begin
        if (reset) begin
            aux_locked <= 1'b0;
        end else if (aux_lock_achieved) begin
            aux_locked <= 1'b1;
        end else if (aux_ref_lost) begin
            aux_locked <= 1'b0;
        end
    end
endmodule

// *** verilog/holdover_iir.sv ***
// First-order averaging filter of the loop frequency word
`timescale 1ns/1ps
module holdover_iir #(
    parameter int FRAC = 16,
    parameter int FAST_SHIFT = holdover_pkg::FILT_FAST_SHIFT,
    parameter int SLOW_SHIFT = holdover_pkg::FILT_SLOW_SHIFT,
    parameter logic [31:0] TICK_CYCLES = 32'(holdover_pkg::FILT_TICK_CYCLES)
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic enable,
    input wire logic short_sel,
    input wire logic [18:0] sample_in,
    output logic [18:0] filt_out
);
    import holdover_pkg::*;

    localparam int AW = FREQ_W + 1 + FRAC;

    logic [31:0] tick_cnt_reg;
    logic primed_reg;
    logic signed [AW-1:0] acc_reg;
    logic tick;
    logic signed [AW-1:0] target;
    logic signed [AW-1:0] diff;
    logic signed [AW-1:0] step;

    assign tick = (tick_cnt_reg == TICK_CYCLES - 32'h1);
    assign target = $signed({sample_in[18], sample_in, {FRAC{1'b0}}});
    assign diff = target - acc_reg;
    assign step = short_sel ? (diff >>> FAST_SHIFT) : (diff >>> SLOW_SHIFT);
    assign filt_out = acc_reg[FRAC+18:FRAC];

    always_ff @(posedge mclk) begin
        if (reset || tick) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end

    // First sample loads directly so the average does not start from zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            acc_reg <= '0;
            primed_reg <= 1'b0;
        end else if (enable && tick) begin
            acc_reg <= primed_reg ? acc_reg + step : target;
            primed_reg <= 1'b1;
        end
    end
endmodule

// *** verilog/holdover_pkg.sv ***
// Shared constants and types for the holdover frequency control block
package holdover_pkg;

    // Register offsets on the configuration port
    localparam logic [7:0] ADDR_FREQ_STS_C = 8'h07;
    localparam logic [7:0] ADDR_STATE_RPT = 8'h09;
    localparam logic [7:0] ADDR_FREQ_STS_A = 8'h0C;
    localparam logic [7:0] ADDR_FREQ_STS_B = 8'h0D;
    localparam logic [7:0] ADDR_INPUT_CFG = 8'h34;
    localparam logic [7:0] ADDR_HOLD_SET_A = 8'h3E;
    localparam logic [7:0] ADDR_HOLD_SET_B = 8'h3F;
    localparam logic [7:0] ADDR_HOLD_CFG = 8'h40;

    // Field positions
    localparam int MANUAL_HOLD_BIT = 4;
    localparam int AVERAGING_BIT = 7;
    localparam int SHORT_FILTER_BIT = 6;
    localparam int READBACK_BIT = 5;
    localparam int FREEZE_SRC_LSB = 3;
    localparam int FREQ_W = 19;

    // Reset values of the writable registers
    localparam logic [7:0] INPUT_CFG_RST = 8'h00;
    localparam logic [7:0] HOLD_CFG_RST = 8'h00;
    localparam logic [18:0] HOLD_SET_RST = 19'h00000;
    localparam logic [18:0] FREQ_ZERO = 19'h00000;

    // Timing
    localparam longint CLK_HZ = 200_000_000;
    localparam longint PRELOCK2_TIMEOUT_S = 100;
    localparam longint PRELOCK2_CYCLES = PRELOCK2_TIMEOUT_S * CLK_HZ;
    localparam longint FILT_TICK_US = 74_000;
    localparam longint FILT_TICK_CYCLES = FILT_TICK_US * CLK_HZ / 1_000_000;
    localparam int FILT_FAST_SHIFT = 10;
    localparam int FILT_SLOW_SHIFT = 14;

    // Primary loop state codes as reported
    typedef enum logic [2:0] {
        LOOP_FREE_RUN = 3'b001,
        LOOP_HOLDOVER = 3'b010,
        LOOP_LOCKED = 3'b100,
        LOOP_PRELOCK2 = 3'b110
    } loop_state_t;

    // Brief freeze frequency source codes
    localparam logic [1:0] FRZ_LAST_GOOD = 2'h0;
    localparam logic [1:0] FRZ_AVERAGED = 2'h1;
    localparam logic [1:0] FRZ_HOLD_SET = 2'h2;
    localparam logic [1:0] FRZ_ZERO = 2'h3;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic source_applied;
        logic source_changed;
        logic ref_invalid;
        logic replacement_avail;
        logic revertive;
        logic higher_prio_restored;
        logic lock_achieved;
        logic input_stopped;
    } loop_events_t;

    typedef struct packed {
        logic active;
        logic [18:0] word;
    } freq_override_t;

endpackage

// *** verilog/prelock2_timer.sv ***
// Timeout counter for the second pre-locked state
`timescale 1ns/1ps
module prelock2_timer #(
    parameter int W = 36,
    parameter logic [35:0] LIMIT = 36'(holdover_pkg::PRELOCK2_CYCLES)
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    output logic expired
);
    logic [W-1:0] count_reg;
    logic at_limit;

    assign at_limit = (count_reg == W'(LIMIT - 36'h1));

    always_ff @(posedge mclk) begin
        if (reset || !run || at_limit) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            expired <= 1'b0;
        end else begin
            expired <= run && at_limit;
        end
    end
endmodule
